// ---- srst_pkg.sv ----
// Constants, register map and types shared by the system reset controller
package srst_pkg;

	// System clock
	localparam int CLK_MHZ = 250;

	// Low-speed oscillator stop detection, typical time as printed
	localparam int OSC_STOP_TIME_US = 3000;
	localparam int OSC_STOP_CYCLES = OSC_STOP_TIME_US * CLK_MHZ;
	localparam int OSC_CNT_W = 20;

	// Watchdog timing, counted in low-speed oscillator ticks
	localparam int LS_OSC_HZ = 32768;
	localparam int WDT_MIN_PERIOD_MS = 250;
	localparam int WDT_BASE_TICKS = LS_OSC_HZ * WDT_MIN_PERIOD_MS / 1000;
	localparam int WDT_CNT_W = 24;
	localparam int WDT_SEL_W = 2;
	localparam logic [WDT_SEL_W-1:0] WDT_SEL_RESET = 2'h0;

	// Length of the reset hold phase before vectors are fetched
	localparam int RESET_HOLD_CYCLES = 16;
	localparam int HOLD_CNT_W = 5;

	// Register addresses
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CAUSE = 16'hf001;
	localparam logic [ADDR_W-1:0] ADDR_WDT_CTRL = 16'hf0e0;
	localparam logic [ADDR_W-1:0] ADDR_WDT_KICK = 16'hf0e1;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 16'hf0e2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 16'hf0e3;

	// Reset cause flag layout
	localparam int CAUSE_POR_BIT = 0;
	localparam int CAUSE_OSC_BIT = 1;
	localparam int CAUSE_WDT_BIT = 2;
	localparam logic [DATA_W-1:0] CAUSE_RESET_VAL = 8'h01;

	// Interrupt status and mask layout
	localparam int IRQ_W = 2;
	localparam int IRQ_WDT_WARN_BIT = 0;
	localparam int IRQ_OSC_WARN_BIT = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 2'h0;

	// Vector table byte addresses
	localparam logic [ADDR_W-1:0] SP_VEC_ADDR = 16'h0000;
	localparam logic [ADDR_W-1:0] PC_VEC_ADDR = 16'h0002;
	localparam logic [ADDR_W-1:0] BRK_PC_VEC_ADDR = 16'h0004;

	// Interrupt level field of the processor status word
	localparam int LEVEL_W = 2;
	localparam logic [LEVEL_W-1:0] BRK_LOW_LEVEL_MAX = 2'h1;

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_FETCH_SP,
		ST_FETCH_PC,
		ST_LOAD_PC,
		ST_RUN
	} srst_state_e;

endpackage

// ---- srst_sync3.sv ----
// Three-stage synchroniser with agreement filter for one asynchronous level
`timescale 1ns/1ps
module srst_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Asynchronous level and its clean copy
	input wire logic async_in,
	output logic level_out
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} srst_sync_s;

	localparam srst_sync_s SYNC_RESET = '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, lvl: RESET_VAL};

	srst_sync_s q;
	srst_sync_s d;

	// The first stage feeds only the second; the filter compares stages two and three
	always_comb begin
		d = q;
		d.s1 = async_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3) begin
			d.lvl = q.s3;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= SYNC_RESET;
		end else begin
			q <= d;
		end
	end

	assign level_out = q.lvl;

endmodule

// ---- srst_reset_ctrl.sv ----
// System reset controller: source merging, cause flags, watchdog and vector fetch
`timescale 1ns/1ps

// Overview of operation
// - Any of five reset sources resets the device; all but software break give a system reset.
// - Missing low-speed oscillation for the detection time raises a reset.
// - Watchdog overflow period selectable as 250 ms, 1 s, 4 s or 16 s.
// - Software break resets only the CPU; RAM and SFRs keep values.
// - Cause flags survive resets; only the actual cause's flag is set.
// - Power-on flag in bit 0 is set on every power-on reset.
// - Oscillator stop flag in bit 1 set when stop detection causes reset.
// - Watchdog flag in bit 2 set when watchdog overflow causes reset.
// - External pin resets set no cause flag.
// - System reset overrides everything and abandons work in progress.
// - Power circuit is initialised on every reset except software break.
// - SFRs with defined initial values reset, except on software break.
// - Every reset, software break included, initialises the CPU registers.
// - Stack pointer is loaded from program memory word at 0000H.
// - Program counter from 0002H, or 0004H for break at level one or lower.
// - Data memory and undefined-value SFRs are left untouched by reset.
module srst_reset_ctrl
	import srst_pkg::*;
#(
	parameter int OSC_STOP_LIMIT = OSC_STOP_CYCLES,
	parameter int WDT_TICKS = WDT_BASE_TICKS
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Reset sources
	input wire logic ext_resetn_pin_in,
	input wire logic por_detect_in,
	input wire logic lowspeed_osc_in,
	input wire logic software_break_instruction_in,
	input wire logic [srst_pkg::LEVEL_W-1:0] interrupt_level_field_in,
	// Register port
	input wire logic [srst_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [srst_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [srst_pkg::DATA_W-1:0] reg_rdata_out,
	// Program memory port for vector fetch
	output logic [srst_pkg::ADDR_W-1:0] rom_addr_out,
	output logic rom_rd_out,
	input wire logic [15:0] rom_data_in,
	// Reset outputs to the CPU, SFRs and power circuit
	output logic cpu_reset_out,
	output logic sfr_reset_out,
	output logic power_circuit_init_out,
	// Vector loads into the CPU
	output logic stack_pointer_load_out,
	output logic [15:0] stack_pointer_out,
	output logic program_counter_load_out,
	output logic [15:0] program_counter_out,
	// Interrupt
	output logic irq_out
);

	import srst_pkg::*;

	localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_STOP_LIMIT - 1);
	localparam logic [OSC_CNT_W-1:0] OSC_HALF = OSC_CNT_W'(OSC_STOP_LIMIT / 2);
	localparam logic [WDT_CNT_W-1:0] WDT_BASE = WDT_CNT_W'(WDT_TICKS);
	localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(RESET_HOLD_CYCLES - 1);

	typedef struct packed {
		srst_state_e state;
		logic [HOLD_CNT_W-1:0] hold_cnt;
		logic full_rst;
		logic brk_vec;
		logic [DATA_W-1:0] cause;
		logic [WDT_SEL_W-1:0] wdt_sel;
		logic [WDT_CNT_W-1:0] wdt_cnt;
		logic wdt_first;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [OSC_CNT_W-1:0] osc_cnt;
		logic osc_stopped;
		logic ls_prev;
		logic [DATA_W-1:0] rdata;
		logic [ADDR_W-1:0] rom_addr;
		logic rom_rd;
		logic [15:0] sp;
		logic [15:0] pc;
		logic sp_ld;
		logic pc_ld;
		logic cpu_rst;
		logic sfr_rst;
		logic pwr_init;
		logic irq;
	} srst_state_s;

	// Power-up looks like a full reset with the power-on flag already set
	localparam srst_state_s CTRL_RESET = '{
		state: ST_HOLD,
		hold_cnt: '0,
		full_rst: 1'b1,
		brk_vec: 1'b0,
		cause: CAUSE_RESET_VAL,
		wdt_sel: WDT_SEL_RESET,
		wdt_cnt: '0,
		wdt_first: 1'b0,
		irq_stat: IRQ_RESET_VAL,
		irq_mask: IRQ_RESET_VAL,
		osc_cnt: '0,
		osc_stopped: 1'b0,
		ls_prev: 1'b0,
		rdata: '0,
		rom_addr: SP_VEC_ADDR,
		rom_rd: 1'b0,
		sp: '0,
		pc: '0,
		sp_ld: 1'b0,
		pc_ld: 1'b0,
		cpu_rst: 1'b1,
		sfr_rst: 1'b1,
		pwr_init: 1'b1,
		irq: 1'b0
	};

	srst_state_s q;
	srst_state_s d;

	logic ext_pin_lvl;
	logic por_lvl;
	logic ls_lvl;

	// Pin-side sources pass the three-stage filter before use
	srst_sync3 #(.RESET_VAL(1'b1)) u_sync_pin (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.async_in(ext_resetn_pin_in),
		.level_out(ext_pin_lvl)
	);

	srst_sync3 #(.RESET_VAL(1'b0)) u_sync_por (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.async_in(por_detect_in),
		.level_out(por_lvl)
	);

	srst_sync3 #(.RESET_VAL(1'b0)) u_sync_ls (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.async_in(lowspeed_osc_in),
		.level_out(ls_lvl)
	);

	logic ls_tick;
	logic osc_event;
	logic wdt_event;
	logic wdt_kick;
	logic full_src;
	logic brk_src;
	logic [WDT_CNT_W-1:0] wdt_limit;
	logic [IRQ_W-1:0] irq_set;
	logic [DATA_W-1:0] cause_set;

	always_comb begin
		d = q;
		d.sp_ld = 1'b0;
		d.pc_ld = 1'b0;
		d.rom_rd = 1'b0;
		d.rdata = '0;
		irq_set = '0;
		cause_set = '0;
		osc_event = 1'b0;
		wdt_event = 1'b0;

		// Low-speed oscillator stop detector runs on the system clock
		// A rising edge of the filtered slow clock is one watchdog tick
		ls_tick = ls_lvl & ~q.ls_prev;
		d.ls_prev = ls_lvl;
		if (ls_lvl != q.ls_prev) begin
			d.osc_cnt = '0;
			d.osc_stopped = 1'b0;
		end else if (q.osc_cnt == OSC_LAST) begin
			d.osc_stopped = 1'b1;
		end else begin
			d.osc_cnt = q.osc_cnt + 1'b1;
		end
		// Early warning halfway through the detection time
		if (ls_lvl == q.ls_prev && q.osc_cnt == OSC_HALF) begin
			irq_set[IRQ_OSC_WARN_BIT] = 1'b1;
		end
		// Only the first stopped cycle counts, so a long stop flags its cause once
		osc_event = d.osc_stopped & ~q.osc_stopped;

		// Watchdog: first overflow warns, second overflow resets
		wdt_limit = WDT_BASE << {q.wdt_sel, 1'b0};
		// Any write to the kick address restarts the count; the data is ignored
		wdt_kick = reg_wr_in && reg_addr_in == ADDR_WDT_KICK;
		if (q.cpu_rst || wdt_kick) begin
			d.wdt_cnt = '0;
			d.wdt_first = 1'b0;
		end else if (ls_tick) begin
			// At or past the limit, so shortening the period mid-count cannot leave the count to wrap
			if (q.wdt_cnt >= wdt_limit - 1'b1) begin
				d.wdt_cnt = '0;
				if (q.wdt_first) begin
					wdt_event = 1'b1;
					d.wdt_first = 1'b0;
				end else begin
					d.wdt_first = 1'b1;
					irq_set[IRQ_WDT_WARN_BIT] = 1'b1;
				end
			end else begin
				d.wdt_cnt = q.wdt_cnt + 1'b1;
			end
		end

		// Source merge; the pin and the break set no cause flag
		full_src = ~ext_pin_lvl | por_lvl | q.osc_stopped | wdt_event;
		// A break is honoured only while running; one during the vector fetch is dropped
		brk_src = software_break_instruction_in && q.state == ST_RUN;
		// The power-on flag is set on every cycle the detector still holds
		cause_set[CAUSE_POR_BIT] = por_lvl;
		cause_set[CAUSE_OSC_BIT] = osc_event;
		cause_set[CAUSE_WDT_BIT] = wdt_event;

		// Register writes; a software write that meets a cause event loses to it
		if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_CAUSE: d.cause = reg_wdata_in;
				ADDR_WDT_CTRL: d.wdt_sel = reg_wdata_in[WDT_SEL_W-1:0];
				ADDR_IRQ_STAT: d.irq_stat = q.irq_stat & ~reg_wdata_in[IRQ_W-1:0];
				ADDR_IRQ_MASK: d.irq_mask = reg_wdata_in[IRQ_W-1:0];
				default: ;
			endcase
		end
		d.cause = d.cause | cause_set;
		d.irq_stat = d.irq_stat | irq_set;

		// SFRs with defined values return to them, but not on a break reset
		// Cause flags are left out on purpose: only power-up loads their start value and they must survive
		if (q.sfr_rst) begin
			d.wdt_sel = WDT_SEL_RESET;
			d.irq_stat = IRQ_RESET_VAL;
			d.irq_mask = IRQ_RESET_VAL;
		end

		// Register reads answer in the next cycle
		if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_CAUSE: d.rdata = q.cause;
				ADDR_WDT_CTRL: d.rdata = DATA_W'(q.wdt_sel);
				ADDR_IRQ_STAT: d.rdata = DATA_W'(q.irq_stat);
				ADDR_IRQ_MASK: d.rdata = DATA_W'(q.irq_mask);
				default: d.rdata = '0;
			endcase
		end

		// Reset sequencer; a full reset request restarts it from any state, a break only from run
		if (full_src) begin
			d.state = ST_HOLD;
			d.hold_cnt = '0;
			d.full_rst = 1'b1;
			d.brk_vec = 1'b0;
			d.cpu_rst = 1'b1;
			d.sfr_rst = 1'b1;
			d.pwr_init = 1'b1;
		end else if (brk_src) begin
			d.state = ST_HOLD;
			d.hold_cnt = '0;
			d.full_rst = 1'b0;
			d.brk_vec = interrupt_level_field_in <= BRK_LOW_LEVEL_MAX;
			d.cpu_rst = 1'b1;
		end else begin
			case (q.state)
				ST_HOLD: begin
					if (q.hold_cnt == HOLD_LAST) begin
						d.state = ST_FETCH_SP;
						// A break reset never raised these, so only a full reset releases them
						if (q.full_rst) begin
							d.sfr_rst = 1'b0;
							d.pwr_init = 1'b0;
						end
						d.rom_addr = SP_VEC_ADDR;
						d.rom_rd = 1'b1;
					end else begin
						d.hold_cnt = q.hold_cnt + 1'b1;
					end
				end
				ST_FETCH_SP: begin
					d.state = ST_FETCH_PC;
					d.rom_addr = q.brk_vec ? BRK_PC_VEC_ADDR : PC_VEC_ADDR;
					d.rom_rd = 1'b1;
				end
				ST_FETCH_PC: begin
					d.state = ST_LOAD_PC;
					d.sp = rom_data_in;
					d.sp_ld = 1'b1;
				end
				ST_LOAD_PC: begin
					d.state = ST_RUN;
					d.pc = rom_data_in;
					d.pc_ld = 1'b1;
					d.cpu_rst = 1'b0;
					d.brk_vec = 1'b0;
				end
				ST_RUN: begin
					d.cpu_rst = 1'b0;
				end
				default: begin
					// An illegal state falls back into a fresh reset hold
					d.state = ST_HOLD;
					d.hold_cnt = '0;
					d.cpu_rst = 1'b1;
				end
			endcase
		end

		// Level interrupt while any unmasked status bit is set
		d.irq = |(d.irq_stat & d.irq_mask);
	end

	// Cause flags keep their value through every reset but power loss
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= CTRL_RESET;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_out = q.rdata;
	assign rom_addr_out = q.rom_addr;
	assign rom_rd_out = q.rom_rd;
	assign cpu_reset_out = q.cpu_rst;
	assign sfr_reset_out = q.sfr_rst;
	assign power_circuit_init_out = q.pwr_init;
	assign stack_pointer_load_out = q.sp_ld;
	assign stack_pointer_out = q.sp;
	assign program_counter_load_out = q.pc_ld;
	assign program_counter_out = q.pc;
	assign irq_out = q.irq;

endmodule

// ---- srst_monitor.sv ----
// Port checker for the system reset controller
`timescale 1ns/1ps
module srst_monitor
	import srst_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Reset sources
	input wire logic ext_resetn_pin_in,
	input wire logic por_detect_in,
	input wire logic software_break_instruction_in,
	// Vector fetch
	input wire logic [srst_pkg::ADDR_W-1:0] rom_addr_out,
	input wire logic rom_rd_out,
	input wire logic [15:0] rom_data_in,
	// Reset and load outputs
	input wire logic cpu_reset_out,
	input wire logic sfr_reset_out,
	input wire logic power_circuit_init_out,
	input wire logic stack_pointer_load_out,
	input wire logic [15:0] stack_pointer_out,
	input wire logic program_counter_load_out,
	input wire logic [15:0] program_counter_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_sp_fetch;
		rom_rd_out && rom_addr_out == SP_VEC_ADDR;
	endsequence
	sequence s_load;
		stack_pointer_load_out ##1 program_counter_load_out && !cpu_reset_out;
	endsequence
	property p_fetch;
		$fell(sfr_reset_out) |-> s_sp_fetch ##1 rom_rd_out && rom_addr_out == PC_VEC_ADDR ##1 s_load;
	endproperty
	a_fetch: assert property (p_fetch) else $error("vector fetch out of order");
	property p_sp; stack_pointer_load_out |-> stack_pointer_out == $past(rom_data_in); endproperty
	a_sp: assert property (p_sp) else $error("stack pointer word wrong");
	property p_pc; program_counter_load_out |-> program_counter_out == $past(rom_data_in); endproperty
	a_pc: assert property (p_pc) else $error("program counter word wrong");
	property p_pin; !ext_resetn_pin_in [*8] |-> cpu_reset_out && sfr_reset_out; endproperty
	a_pin: assert property (p_pin) else $error("pin reset not taken");
	property p_por; por_detect_in [*8] |-> cpu_reset_out && sfr_reset_out; endproperty
	a_por: assert property (p_por) else $error("power-on reset not taken");
	property p_brk;
		software_break_instruction_in && !cpu_reset_out |-> ##[1:2] (cpu_reset_out && !sfr_reset_out);
	endproperty
	a_brk: assert property (p_brk) else $error("break reset wrong");
	property p_pwr; sfr_reset_out == power_circuit_init_out; endproperty
	a_pwr: assert property (p_pwr) else $error("power init differs from sfr init");
	property p_cpu; sfr_reset_out |-> cpu_reset_out; endproperty
	a_cpu: assert property (p_cpu) else $error("cpu left out of reset");
endmodule
bind srst_reset_ctrl srst_monitor u_mon (.*);

// ---- srst_rom_model.sv ----
// Program memory model answering vector reads one cycle late
`timescale 1ns/1ps
module srst_rom_model
	import srst_pkg::*;
#(
	parameter logic [15:0] SP_WORD = 16'h0ffe,
	parameter logic [15:0] PC_WORD = 16'h0200,
	parameter logic [15:0] BRK_WORD = 16'h0300
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Read port
	input wire logic rom_rd_in,
	input wire logic [15:0] rom_addr_in,
	output logic [15:0] rom_data_out
);
	// Outside reads the word toggles so a late sample never matches
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rom_data_out <= 16'h5a5a;
		end else if (rom_rd_in) begin
			case (rom_addr_in)
				SP_VEC_ADDR: rom_data_out <= SP_WORD;
				PC_VEC_ADDR: rom_data_out <= PC_WORD;
				BRK_PC_VEC_ADDR: rom_data_out <= BRK_WORD;
				default: rom_data_out <= ~rom_data_out;
			endcase
		end else begin
			rom_data_out <= ~rom_data_out;
		end
	end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the system reset controller
`timescale 1ns/1ps
module tb_top;
	import srst_pkg::*;
	localparam logic [15:0] SPW = 16'h0ffe;
	localparam logic [15:0] PCW = 16'h0200;
	localparam logic [15:0] BKW = 16'h0300;
	logic mclk_in = 0, resetn_in = 0, pin_n = 1, por = 0, osc = 0, osc_en = 1, software_break_instruction = 0, wr = 0, rd = 0;
	logic [1:0] lvl = 0;
	logic [15:0] addr = 0, rom_addr, rom_data, sp, pc;
	logic [7:0] wdata = 0, rdata;
	logic rom_rd, cpu_rst, sfr_rst, pwr, sp_ld, pc_ld, irq;
	int n_errors = 0, checks = 0, cyc = 0;
	always #2 mclk_in = ~mclk_in;
	// Slow clock half period stays well under the stop limit of 64
	always begin
		repeat (40) @(posedge mclk_in);
		if (osc_en) osc <= ~osc;
	end
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			results;
		end
	end
	srst_reset_ctrl #(.OSC_STOP_LIMIT(64), .WDT_TICKS(4)) dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.ext_resetn_pin_in(pin_n), .por_detect_in(por), .lowspeed_osc_in(osc),
		.software_break_instruction_in(software_break_instruction), .interrupt_level_field_in(lvl), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rom_addr_out(rom_addr),
		.rom_rd_out(rom_rd), .rom_data_in(rom_data), .cpu_reset_out(cpu_rst), .sfr_reset_out(sfr_rst),
		.power_circuit_init_out(pwr), .stack_pointer_load_out(sp_ld), .stack_pointer_out(sp),
		.program_counter_load_out(pc_ld), .program_counter_out(pc), .irq_out(irq));
	srst_rom_model #(.SP_WORD(SPW), .PC_WORD(PCW), .BRK_WORD(BKW)) rom (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .rom_rd_in(rom_rd), .rom_addr_in(rom_addr), .rom_data_out(rom_data));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge mclk_in);
		wr <= 0;
	endtask
	task rd_reg(input logic [15:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		rd <= 1;
		addr <= a;
		@(posedge mclk_in);
		rd <= 0;
		#1 chk(rdata, exp);
	endtask
	task pulse_wait(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task wait_run(input logic [15:0] exp_pc);
		int n;
		n = 0;
		while (pc_ld !== 1'b1 && n < 2000) begin
			@(posedge mclk_in);
			#1 n++;
		end
		chk({pc_ld, cpu_rst}, 2'b10);
		chk(sp, SPW);
		chk(pc, exp_pc);
		wr_reg(ADDR_WDT_KICK, 0);
	endtask
	task t_power;
		wait_run(PCW);
		rd_reg(ADDR_CAUSE, CAUSE_RESET_VAL);
		rd_reg(16'hf0ff, 0);
		wr_reg(ADDR_CAUSE, 0);
		rd_reg(ADDR_CAUSE, 0);
		wr_reg(ADDR_CAUSE, 8'ha0);
		rd_reg(ADDR_CAUSE, 8'ha0);
	endtask
	task t_pin;
		wr_reg(ADDR_IRQ_MASK, 8'h02);
		pin_n <= 0;
		pulse_wait(10);
		chk({cpu_rst, sfr_rst, pwr}, 3'b111);
		@(posedge mclk_in);
		pin_n <= 1;
		wait_run(PCW);
		rd_reg(ADDR_CAUSE, 8'ha0);
		rd_reg(ADDR_IRQ_MASK, 0);
		@(posedge mclk_in);
		por <= 1;
		pulse_wait(10);
		@(posedge mclk_in);
		por <= 0;
		wait_run(PCW);
		rd_reg(ADDR_CAUSE, 8'ha1);
	endtask
	task t_osc;
		@(posedge mclk_in);
		osc_en <= 0;
		pulse_wait(150);
		chk({cpu_rst, sfr_rst, pwr}, 3'b111);
		rd_reg(ADDR_CAUSE, 8'ha3);
		@(posedge mclk_in);
		osc_en <= 1;
		wait_run(PCW);
		rd_reg(ADDR_CAUSE, 8'ha3);
	endtask
	task t_wdt;
		int n;
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		for (int s = 3; s >= 0; s--) begin
			wr_reg(ADDR_WDT_CTRL, 8'(s));
			wr_reg(ADDR_WDT_KICK, 0);
			wr_reg(ADDR_IRQ_STAT, 8'h01);
			n = 0;
			// Step off the edge so the clear's own update is seen, not the stale level
			#1;
			while (irq !== 1'b1 && n < 25000) begin
				@(posedge mclk_in);
				#1 n++;
			end
			chk(n > ((4 << (2 * s)) - 1) * 80 - 8 && n < (4 << (2 * s)) * 80 + 8, 1);
		end
		wr_reg(ADDR_IRQ_MASK, 0);
		pulse_wait(1);
		chk(irq, 0);
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		pulse_wait(1);
		chk(irq, 1);
		wr_reg(ADDR_IRQ_STAT, 8'h01);
		pulse_wait(1);
		chk(irq, 0);
		n = 0;
		while (sfr_rst !== 1'b1 && n < 400) begin
			@(posedge mclk_in);
			#1 n++;
		end
		chk(sfr_rst, 1);
		wait_run(PCW);
		rd_reg(ADDR_CAUSE, 8'ha7);
	endtask
	task t_brk;
		wr_reg(ADDR_IRQ_MASK, 8'h02);
		pulse_wait(41);
		chk(irq, 1);
		for (int l = 0; l < 4; l++) begin
			@(posedge mclk_in);
			software_break_instruction <= 1;
			lvl <= 2'(l);
			@(posedge mclk_in);
			software_break_instruction <= 0;
			pulse_wait(1);
			chk({cpu_rst, sfr_rst, pwr}, 3'b100);
			wait_run(l <= 1 ? BKW : PCW);
			rd_reg(ADDR_IRQ_MASK, 8'h02);
			rd_reg(ADDR_CAUSE, 8'ha7);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1;
		t_power;
		t_pin;
		t_osc;
		t_wdt;
		t_brk;
		results;
	end
endmodule
